/* File: bench/adcrb_far_model.sv */
/*
  Far-side model: converter that answers each start with one result beat, and
  a DMA controller that acknowledges each request after a short or long delay.
  Assumes the block under test on the same pclk; bench sets base, clr, slow.
*/
`timescale 1ns/10ps

module adcrb_far_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // converter side
  input  wire logic        conv_start,
  output logic             conv_valid,
  input  wire logic        conv_ready,
  output logic      [15:0] conv_data,
  // bench controls
  input  wire logic [15:0] base,
  input  wire logic        clr,
  input  wire logic        slow,
  // dma controller side
  input  wire logic        dma_req,
  output logic             dma_ack
);
  logic [7:0]  wait_cnt;  // cycles left in the conversion
  logic        busy;      // conversion under way
  logic [15:0] beats;     // results handed over since clr
  logic [2:0]  ack_dly;   // dma answer delay count

  ////////////////////////////////////////////////////////////////////////////
  // converter and dma controller, one process
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy, conv_valid, dma_ack} <= 3'h0;
      {wait_cnt, ack_dly} <= 11'h000;
      {conv_data, beats} <= 32'h0000_0000;
    end else begin
      if (conv_start) begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 8'h28 : 8'h03;  // slow keeps the old value visible longer
      end else if (busy && wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else if (busy && !conv_valid) begin
        conv_valid <= 1'b1;
        conv_data  <= base + beats;
      end
      // beat held until taken; data turned over afterwards so stale is never read
      if (conv_valid && conv_ready) begin
        conv_valid <= 1'b0;
        busy       <= 1'b0;
        beats      <= beats + 16'h0001;
        conv_data  <= ~conv_data;
      end
      if (clr) begin
        beats <= 16'h0000;
      end
      dma_ack <= 1'b0;
      if (dma_req && !dma_ack) begin
        if (ack_dly == (slow ? 3'h5 : 3'h1)) begin
          dma_ack <= 1'b1;
          ack_dly <= 3'h0;
        end else begin
          ack_dly <= ack_dly + 3'h1;
        end
      end
    end
  end
endmodule : adcrb_far_model

/* File: bench/adcrb_tb_top.sv */
/*
  Self-checking bench for the result buffer block: table of conversions, then
  trigger modes, interrupt sources, DMA mode and a full FIFO fill and drain.
  Assumes the far-side model for converter and DMA, APB with one wait state.
*/
`timescale 1ns/10ps

module adcrb_tb_top;
  typedef struct packed {logic res12; logic [15:0] smp; logic [15:0] exp;} adcrb_row_s;
  localparam logic [31:0] IEN = 32'h1 << adcrb_pkg::IRQ_EN_BIT;   // interrupt enable
  localparam logic [31:0] FEN = 32'h1 << adcrb_pkg::MODE_FIFO_BIT; // fifo enable
  localparam logic [31:0] DEN = 32'h1 << adcrb_pkg::MODE_DMA_BIT;  // dma mode
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, prev, s;
  logic conv_start, conv_valid, conv_ready, pacer_trig, ext_trig, ext_irq, timer_out;
  logic dma_req, dma_ack, dma_terminal_count, irq, clr, slow, e;
  logic [15:0] conv_data, dma_data, base;
  int bad_count = 0, compares = 0, cyc = 0, irq_cnt = 0, st_cnt = 0, k;
  // ordinary cases: format and left alignment
  adcrb_row_s rows [8] = '{'{1'b0, 16'h7FFF, 16'h7FFF}, '{1'b0, 16'h8000, 16'h8000},
    '{1'b0, 16'h0001, 16'h0001}, '{1'b0, 16'hFFFF, 16'hFFFF}, '{1'b1, 16'h7FFF, 16'h7FF0},
    '{1'b1, 16'h801F, 16'h8010}, '{1'b1, 16'hFFFF, 16'hFFF0}, '{1'b1, 16'h000F, 16'h0000}};

  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // eoc pulses counted between edges
  always @(negedge pclk) irq_cnt += (irq === 1'b1) ? 1 : 0;
  // conversion start pulses counted the same way
  always @(negedge pclk) st_cnt += (conv_start === 1'b1) ? 1 : 0;

  adcrb_top adcrb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_data(conv_data), .pacer_trig(pacer_trig),
    .ext_trig(ext_trig), .ext_irq(ext_irq), .timer_out(timer_out), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_terminal_count(dma_terminal_count), .dma_data(dma_data),
    .irq(irq));
  adcrb_far_model adcrb_far_model_inst (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_data(conv_data), .base(base), .clr(clr), .slow(slow), .dma_req(dma_req),
    .dma_ack(dma_ack));

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // apb master: hold request until pready, take data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      bad_count++;
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d, q, err);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic err;
    apb(1'b0, a, 32'h0, q, err);
  endtask : rd

  // land on a settled half cycle after n edges
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // poll the conversion flag, bounded, and time it from the trigger
  task automatic wait_conv();
    int i, t0;
    t0 = cyc;
    for (i = 0; i < 150; i++) begin
      rd(adcrb_pkg::STATUS_OFS, s);
      if (s[adcrb_pkg::ST_CONV_BIT] === 1'b1) break;
    end
    if (i == 150) begin
      bad_count++;
      summarize();
    end
    chk(32'((cyc - t0) <= adcrb_pkg::CONV_CYC), 32'h1);
  endtask : wait_conv

  task automatic wait_req(input logic v);
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge pclk);
      if (dma_req === v) break;
    end
    if (i == 100) begin
      bad_count++;
      summarize();
    end
  endtask : wait_req

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, pacer_trig, ext_trig, ext_irq, timer_out} = 8'h00;
    // clr held so every result equals base until the fifo test
    {dma_terminal_count, clr, slow} = 3'h3;
    {paddr, pwdata, base} = 56'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(adcrb_pkg::MODE_OFS, r);
    chk(r, 32'(adcrb_pkg::MODE_RST));
    rd(adcrb_pkg::IRQ_OFS, r);
    chk(r, 32'(adcrb_pkg::IRQ_RST));
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    $display("done: reset and unmapped");
    prev = 32'h0;
    foreach (rows[i]) begin
      base <= rows[i].smp;
      wr(adcrb_pkg::MODE_OFS, 32'(rows[i].res12) << adcrb_pkg::MODE_RES12_BIT);
      wr(adcrb_pkg::SWTRIG_OFS, 32'h0);
      rd(adcrb_pkg::RESULT_OFS, r);
      chk(r, prev);
      wait_conv();
      rd(adcrb_pkg::RESULT_OFS, r);
      chk(r, 32'(rows[i].exp));
      prev = 32'(rows[i].exp);
    end
    $display("done: result table");
    slow <= 1'b0;
    wr(adcrb_pkg::MODE_OFS, 32'(adcrb_pkg::TRIG_PACER));
    base <= 16'h1234;
    pacer_trig <= 1'b1;
    wait_conv();
    pacer_trig <= 1'b0;
    wr(adcrb_pkg::MODE_OFS, 32'(adcrb_pkg::TRIG_EXT));
    base <= 16'h4321;
    ext_trig <= 1'b1;
    wait_conv();
    ext_trig <= 1'b0;
    rd(adcrb_pkg::RESULT_OFS, r);
    chk(r, 32'h4321);
    wr(adcrb_pkg::MODE_OFS, 32'(adcrb_pkg::TRIG_OFF));
    st_cnt = 0;
    ext_trig <= 1'b1;
    settle(20);
    chk(32'(st_cnt), 32'h0);
    @(posedge pclk);
    ext_trig <= 1'b0;
    $display("done: triggers");
    wr(adcrb_pkg::MODE_OFS, 32'(adcrb_pkg::TRIG_SW));
    for (k = 0; k < 2; k++) begin
      wr(adcrb_pkg::IRQ_OFS, IEN | (k == 1 ? 32'h2 : 32'h0));
      ext_irq <= (k == 0);
      timer_out <= (k == 1);
      settle(3);
      chk(32'(irq), 32'h1);
      @(posedge pclk);
      {ext_irq, timer_out} <= 2'h0;
      settle(3);
      chk(32'(irq), 32'h0);
    end
    wr(adcrb_pkg::IRQ_OFS, IEN | 32'(adcrb_pkg::IRQ_EOC));
    irq_cnt = 0;
    wr(adcrb_pkg::SWTRIG_OFS, 32'h0);
    wait_conv();
    settle(3);
    chk(32'(irq_cnt), 32'h1);
    $display("done: interrupt sources");
    wr(adcrb_pkg::IRQ_OFS, IEN | 32'(adcrb_pkg::IRQ_EXT));
    ext_irq <= 1'b1;
    slow <= 1'b1;
    wr(adcrb_pkg::MODE_OFS, DEN);
    settle(3);
    chk(32'(irq), 32'h0);
    @(posedge pclk);
    dma_terminal_count <= 1'b1;
    settle(3);
    chk(32'(irq), 32'h1);
    @(posedge pclk);
    {dma_terminal_count, ext_irq} <= 2'h0;
    for (k = 0; k < 3; k++) begin
      base <= 16'hA000 + 16'(k);
      wr(adcrb_pkg::SWTRIG_OFS, 32'h0);
      wait_req(1'b1);
      chk(32'(dma_data), 32'hA000 + 32'(k));
      wait_req(1'b0);
    end
    $display("done: dma");
    // fill past full with half-full interrupt
    slow <= 1'b0;
    clr <= 1'b1;
    base <= 16'h0100;
    wr(adcrb_pkg::IRQ_OFS, IEN | 32'(adcrb_pkg::IRQ_HALF));
    clr <= 1'b0;
    wr(adcrb_pkg::MODE_OFS, FEN);
    for (k = 0; k < 1026; k++) begin
      wr(adcrb_pkg::SWTRIG_OFS, 32'h0);
      wait_conv();
      settle(2);
      if (k == 510 || k == 511) chk(32'(irq), 32'(k == 511));
    end
    rd(adcrb_pkg::STATUS_OFS, r);
    chk(r & 32'hA, 32'hA);
    for (k = 0; k < 1024; k++) begin
      rd(adcrb_pkg::FIFO_OFS, r);
      chk(r, 32'(16'h0100 + 16'(k)));
    end
    rd(adcrb_pkg::STATUS_OFS, r);
    chk(r & 32'h2, 32'h0);
    $display("done: fifo fill and drain");
    // mid-run reset brings mode and status back to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(adcrb_pkg::MODE_OFS, r);
    chk(r, 32'(adcrb_pkg::MODE_RST));
    rd(adcrb_pkg::STATUS_OFS, r);
    chk(r, 32'h0);
    $display("done: mid-run reset");
    summarize();
  end
endmodule : adcrb_tb_top

/* File: hw/adcrb_pkg.sv */
/*
  Constants for the converter result buffer and interrupt block: register offsets,
  field positions, reset values, FIFO sizes, trigger and interrupt source codes,
  conversion time limit.
  Assumes a 50 MHz APB clock and a 16-bit converter behind a valid/ready port.
*/
package adcrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] RESULT_OFS = 8'h00;  // newest result, read only
  localparam logic [7:0] FIFO_OFS   = 8'h04;  // FIFO port, read pops
  localparam logic [7:0] STATUS_OFS = 8'h08;  // status, read clears sticky errors
  localparam logic [7:0] MODE_OFS   = 8'h0C;  // conversion mode control
  localparam logic [7:0] IRQ_OFS    = 8'h10;  // interrupt source control
  localparam logic [7:0] SWTRIG_OFS = 8'h14;  // write starts a conversion when TRIG_SW is selected

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MODE_TRIG_LSB  = 0;  // [1:0] trigger source
  localparam int MODE_FIFO_BIT  = 2;  // FIFO enable
  localparam int MODE_DMA_BIT   = 3;  // dma_transfer_enable
  localparam int MODE_RES12_BIT = 4;  // 12-bit resolution variant
  localparam int IRQ_SRC_LSB    = 0;  // [1:0] interrupt source
  localparam int IRQ_EN_BIT     = 2;  // interrupt output enable
  localparam int ST_CONV_BIT    = 0;  // newest result present
  localparam int ST_NEMPTY_BIT  = 1;  // fifo_not_empty_flag
  localparam int ST_HALF_BIT    = 2;  // FIFO at least half full
  localparam int ST_FULL_BIT    = 3;  // FIFO full
  localparam int ST_BUSY_BIT    = 4;  // conversion in progress
  localparam int ST_OVF_BIT     = 5;  // sample dropped on full FIFO, sticky
  localparam int ST_TMO_BIT     = 6;  // conversion overran its time, sticky

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [4:0]  MODE_RST   = 5'h00;
  localparam logic [2:0]  IRQ_RST    = 3'h0;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and formats
  localparam int          FIFO_AW    = 10;
  localparam int          FIFO_DEPTH = 1024;
  localparam int          FIFO_HALF  = 512;
  localparam logic [15:0] RES12_MASK = 16'hFFF0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: longest conversion time, rounded down to cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS  = 10000;
  localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // source codes
  typedef enum logic [1:0] {TRIG_SW, TRIG_PACER, TRIG_EXT, TRIG_OFF} adcrb_trig_e;
  typedef enum logic [1:0] {IRQ_EXT, IRQ_EOC, IRQ_TIMER, IRQ_HALF} adcrb_irq_e;

endpackage : adcrb_pkg

/* File: hw/adcrb_top.sv */
/*
  Converter result handling: trigger select, result register, 1K sample FIFO,
  status, interrupt source select and DMA request, behind an APB slave.
  Assumes all inputs synchronous to pclk, a converter that answers each
  conv_start with one conv_valid beat, and a DMA controller on dma_ack.
*/
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

module adcrb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter
  output logic             conv_start,
  input  wire logic        conv_valid,
  output logic             conv_ready,
  input  wire logic [15:0] conv_data,
  // trigger and interrupt sources
  input  wire logic        pacer_trig,
  input  wire logic        ext_trig,
  input  wire logic        ext_irq,
  input  wire logic        timer_out,
  // dma and interrupt
  output logic             dma_req,
  input  wire logic        dma_ack,
  input  wire logic        dma_terminal_count,
  output logic      [15:0] dma_data,
  output logic             irq
);

  localparam int TMO_BOUND = int'(adcrb_pkg::CONV_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic        ack;        // access phase already seen once
    logic        pop_ok;     // FIFO held a sample at data capture
    logic [31:0] prdata;     // captured read data
    logic [1:0]  trig_sel;   // trigger source
    logic        fifo_en;    // FIFO enable
    logic        dma_en;     // dma_transfer_enable
    logic        res12;      // 12-bit variant
    logic [1:0]  irq_src;    // interrupt source
    logic        irq_en;     // interrupt output enable
    logic [15:0] result;     // newest result
    logic        conv_flag;  // newest result present
    logic        busy;       // conversion running
    logic [9:0]  tmo_cnt;    // cycles since start
    logic        timeout;    // conversion overran, sticky
    logic        overflow;   // sample dropped, sticky
    logic        dma_req;    // pending dma transfer
    logic        irq;        // interrupt output
    logic        trig_prev;  // selected trigger, last cycle
    logic        conv_start; // start pulse
    logic [9:0]  wr_ptr;     // FIFO write pointer
    logic [9:0]  rd_ptr;     // FIFO read pointer
    logic [10:0] cnt;        // FIFO occupancy
    logic [15:0] b0;         // skid buffer head
    logic [15:0] b1;         // skid buffer second entry
    logic [1:0]  bcnt;       // skid buffer occupancy
  } adcrb_state_s;

  adcrb_state_s r_reg;                           // registered state
  adcrb_state_s r_next;                          // next state
  logic [15:0]  mem [adcrb_pkg::FIFO_DEPTH];     // sample storage
  logic         push;                            // FIFO write this cycle
  logic         pop;                             // FIFO read completes
  logic         drain;                           // skid buffer hands a result on
  logic         access_done;                     // apb transfer ends this edge
  logic         full;                            // FIFO full
  logic         half;                            // FIFO at least half full

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // decoded offsets answer; all others get pslverr
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == adcrb_pkg::RESULT_OFS) || (a == adcrb_pkg::FIFO_OFS)
             || (a == adcrb_pkg::STATUS_OFS) || (a == adcrb_pkg::MODE_OFS)
             || (a == adcrb_pkg::IRQ_OFS)    || (a == adcrb_pkg::SWTRIG_OFS);
  endfunction : is_mapped

  // two's complement, low nibble cleared for 12-bit variant
  function automatic logic [15:0] fmt_sample(input logic [15:0] d, input logic r12);
    fmt_sample = r12 ? (d & adcrb_pkg::RES12_MASK) : d;
  endfunction : fmt_sample

  assign full        = (r_reg.cnt == 11'(adcrb_pkg::FIFO_DEPTH));
  assign half        = (r_reg.cnt >= 11'(adcrb_pkg::FIFO_HALF));
  assign access_done = psel & penable & r_reg.ack;
  // one wait state: data is captured on the first access cycle
  assign pready      = access_done;
  assign pslverr     = access_done & ~is_mapped(paddr);
  assign prdata      = r_reg.prdata;
  // skid buffer has room for another converter beat
  assign conv_ready  = (r_reg.bcnt != 2'd2);
  assign conv_start  = r_reg.conv_start;
  assign dma_req     = r_reg.dma_req;
  assign dma_data    = r_reg.result;
  assign irq         = r_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        sel_lvl;
    logic        sw_trig;
    logic        in_fire;
    logic        src_lvl;
    logic [31:0] rd;
    logic [1:0]  slot;
    sel_lvl = 1'b0;
    sw_trig = 1'b0;
    in_fire = conv_valid & conv_ready;
    src_lvl = 1'b0;
    rd      = 32'h0000_0000;
    slot    = 2'd0;
    r_next  = r_reg;
    r_next.conv_start = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    // a pop holds the storage port, so the skid buffer waits one cycle
    drain   = (r_reg.bcnt != 2'd0) & ~(access_done & ~pwrite & (paddr == adcrb_pkg::FIFO_OFS));

    // read mux, captured on the first access cycle
    case (paddr)
      adcrb_pkg::RESULT_OFS: rd = {16'h0000, r_reg.result};
      adcrb_pkg::FIFO_OFS:   rd = {16'h0000, mem[r_reg.rd_ptr]};
      adcrb_pkg::STATUS_OFS: begin
        rd[adcrb_pkg::ST_CONV_BIT]   = r_reg.conv_flag;
        rd[adcrb_pkg::ST_NEMPTY_BIT] = (r_reg.cnt != 11'd0);
        rd[adcrb_pkg::ST_HALF_BIT]   = half;
        rd[adcrb_pkg::ST_FULL_BIT]   = full;
        rd[adcrb_pkg::ST_BUSY_BIT]   = r_reg.busy;
        rd[adcrb_pkg::ST_OVF_BIT]    = r_reg.overflow;
        rd[adcrb_pkg::ST_TMO_BIT]    = r_reg.timeout;
      end
      adcrb_pkg::MODE_OFS:   rd = {27'h0, r_reg.res12, r_reg.dma_en, r_reg.fifo_en, r_reg.trig_sel};
      adcrb_pkg::IRQ_OFS:    rd = {29'h0, r_reg.irq_en, r_reg.irq_src};
      default:               rd = 32'h0000_0000;
    endcase

    // apb access phase
    if (psel & penable & ~r_reg.ack) begin
      r_next.ack    = 1'b1;
      r_next.prdata = rd;
      // a push after capture is not in rd, so it must not be popped
      r_next.pop_ok = (paddr == adcrb_pkg::FIFO_OFS) && (r_reg.cnt != 11'd0);
    end
    if (access_done) begin
      r_next.ack = 1'b0;
      if (pwrite) begin
        case (paddr)
          adcrb_pkg::MODE_OFS: begin
            r_next.trig_sel = pwdata[adcrb_pkg::MODE_TRIG_LSB +: 2];
            r_next.fifo_en  = pwdata[adcrb_pkg::MODE_FIFO_BIT];
            r_next.dma_en   = pwdata[adcrb_pkg::MODE_DMA_BIT];
            r_next.res12    = pwdata[adcrb_pkg::MODE_RES12_BIT];
          end
          adcrb_pkg::IRQ_OFS: begin
            r_next.irq_src = pwdata[adcrb_pkg::IRQ_SRC_LSB +: 2];
            r_next.irq_en  = pwdata[adcrb_pkg::IRQ_EN_BIT];
          end
          adcrb_pkg::SWTRIG_OFS: sw_trig = (r_reg.trig_sel == adcrb_pkg::TRIG_SW);
          default: ;
        endcase
      end else begin
        // sticky errors clear on a status read, only the bits it returned
        if (paddr == adcrb_pkg::STATUS_OFS) begin
          r_next.overflow = r_reg.overflow & ~r_reg.prdata[adcrb_pkg::ST_OVF_BIT];
          r_next.timeout  = r_reg.timeout & ~r_reg.prdata[adcrb_pkg::ST_TMO_BIT];
        end
        if ((paddr == adcrb_pkg::FIFO_OFS) && r_reg.pop_ok) begin
          pop = 1'b1;
          r_next.rd_ptr = r_reg.rd_ptr + 10'd1;
        end
      end
    end

    case (r_reg.trig_sel)
      adcrb_pkg::TRIG_PACER: sel_lvl = pacer_trig;
      adcrb_pkg::TRIG_EXT:   sel_lvl = ext_trig;
      default:               sel_lvl = 1'b0;
    endcase
    r_next.trig_prev = sel_lvl;
    // triggers during a running conversion are ignored
    if (((sel_lvl & ~r_reg.trig_prev) | sw_trig) & ~r_reg.busy) begin
      r_next.conv_start = 1'b1;
      r_next.busy       = 1'b1;
      r_next.conv_flag  = 1'b0;
      r_next.tmo_cnt    = 10'd0;
    end

    if (r_reg.busy) begin
      if (r_reg.tmo_cnt == 10'(adcrb_pkg::CONV_CYC - 1)) begin
        r_next.timeout = 1'b1;
      end else begin
        r_next.tmo_cnt = r_reg.tmo_cnt + 10'd1;
      end
    end

    // format on entry to the skid buffer
    if (drain) begin
      r_next.b0   = r_reg.b1;
      r_next.bcnt = r_reg.bcnt - 2'd1;
    end
    if (in_fire) begin
      slot = drain ? r_reg.bcnt - 2'd1 : r_reg.bcnt;
      if (slot == 2'd0) begin
        r_next.b0 = fmt_sample(conv_data, r_reg.res12);
      end else begin
        r_next.b1 = fmt_sample(conv_data, r_reg.res12);
      end
      r_next.bcnt = r_next.bcnt + 2'd1;
    end

    // dma controller takes the pending word
    if (dma_ack) begin
      r_next.dma_req = 1'b0;
    end

    // completion: store, flag, queue, request
    if (drain) begin
      r_next.result    = r_reg.b0;
      r_next.conv_flag = 1'b1;
      r_next.busy      = 1'b0;
      if (r_reg.fifo_en) begin
        if (!full) begin
          push = 1'b1;
          r_next.wr_ptr = r_reg.wr_ptr + 10'd1;
        end else begin
          r_next.overflow = 1'b1;
        end
      end
      if (r_reg.dma_en) begin
        r_next.dma_req = 1'b1;
      end
    end
    r_next.cnt = r_reg.cnt + 11'(push) - 11'(pop);

    case (r_reg.irq_src)
      adcrb_pkg::IRQ_EXT:   src_lvl = ext_irq;
      adcrb_pkg::IRQ_EOC:   src_lvl = drain;
      adcrb_pkg::IRQ_TIMER: src_lvl = timer_out;
      adcrb_pkg::IRQ_HALF:  src_lvl = r_reg.fifo_en & half;
      default:              src_lvl = 1'b0;
    endcase
    // terminal count owns the line in dma mode
    r_next.irq = r_reg.dma_en ? dma_terminal_count : (r_reg.irq_en & src_lvl);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg          <= '0;
      r_reg.trig_sel <= adcrb_pkg::MODE_RST[1:0];
      r_reg.fifo_en  <= adcrb_pkg::MODE_RST[adcrb_pkg::MODE_FIFO_BIT];
      r_reg.dma_en   <= adcrb_pkg::MODE_RST[adcrb_pkg::MODE_DMA_BIT];
      r_reg.res12    <= adcrb_pkg::MODE_RST[adcrb_pkg::MODE_RES12_BIT];
      r_reg.irq_src  <= adcrb_pkg::IRQ_RST[1:0];
      r_reg.irq_en   <= adcrb_pkg::IRQ_RST[adcrb_pkg::IRQ_EN_BIT];
      r_reg.result   <= adcrb_pkg::RESULT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // sample storage; no reset, occupancy guards every pop, but a read of an empty FIFO returns mem as it stands
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[r_reg.wr_ptr] <= r_reg.b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_result_hold;
    @(posedge pclk) disable iff (!presetn) !drain |=> $stable(r_reg.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without completion");

  property p_result_new;
    @(posedge pclk) disable iff (!presetn) drain |=> r_reg.result == $past(r_reg.b0);
  endproperty
  a_result_new: assert property (p_result_new) else $error("result not newest sample");

  property p_drop_full;
    @(posedge pclk) disable iff (!presetn)
      drain && full && !pop |=> r_reg.cnt == 11'(adcrb_pkg::FIFO_DEPTH) && $stable(r_reg.wr_ptr);
  endproperty
  a_drop_full: assert property (p_drop_full) else $error("full FIFO accepted a sample");

  property p_conv_time;
    @(posedge pclk) disable iff (!presetn)
      r_reg.conv_start |-> ##[0:TMO_BOUND] (!r_reg.busy || r_reg.timeout);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time not bounded");

  property p_conv_flag;
    @(posedge pclk) disable iff (!presetn) drain |=> r_reg.conv_flag && !r_reg.busy;
  endproperty
  a_conv_flag: assert property (p_conv_flag) else $error("conversion flag missing");

  property p_pop_order;
    @(posedge pclk) disable iff (!presetn)
      pop |=> r_reg.rd_ptr == $past(r_reg.rd_ptr) + 10'd1;
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("FIFO read did not advance");

  property p_eoc_irq;
    @(posedge pclk) disable iff (!presetn)
      drain && !r_reg.dma_en && r_reg.irq_en && r_reg.irq_src == adcrb_pkg::IRQ_EOC |=> irq;
  endproperty
  a_eoc_irq: assert property (p_eoc_irq) else $error("no interrupt on completion");

  property p_half_irq;
    @(posedge pclk) disable iff (!presetn)
      !r_reg.dma_en && r_reg.irq_en && r_reg.fifo_en && half
      && r_reg.irq_src == adcrb_pkg::IRQ_HALF |=> irq;
  endproperty
  a_half_irq: assert property (p_half_irq) else $error("no half-full interrupt");

  property p_tc_irq;
    @(posedge pclk) disable iff (!presetn)
      r_reg.dma_en |=> irq == $past(dma_terminal_count);
  endproperty
  a_tc_irq: assert property (p_tc_irq) else $error("dma mode interrupt not terminal count");

  property p_dma_req;
    @(posedge pclk) disable iff (!presetn) drain && r_reg.dma_en |=> dma_req;
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("no dma request after result");

  c_fifo_half: cover property (@(posedge pclk) disable iff (!presetn) $rose(half));
  c_fifo_drop: cover property (@(posedge pclk) disable iff (!presetn) drain && full);
  c_stall:     cover property (@(posedge pclk) disable iff (!presetn) r_reg.bcnt == 2'd2);

endmodule : adcrb_top
